/* File: hw/strap_latch_map.vh */
// Strap latch constants: register offsets, field positions, mode codes
`ifndef STRAP_LATCH_MAP_VH
`define STRAP_LATCH_MAP_VH

// Register byte offsets
`define REG_MODE_STATUS   5'h00
`define REG_MGMT_ADDR     5'h04
`define REG_CLOCK_CTRL    5'h08
`define REG_ADV_STATUS    5'h0C
`define REG_RAW_STRAPS    5'h10

// Function select codes
`define FN_RGMII_WAKE_IND 4'h8
`define FN_RGMII_WAKE_IRQ 4'hA
`define FN_RGMII_GIG_ONLY 4'hC
`define FN_RGMII_PLAIN    4'hE
`define FN_NAND_TREE      4'h4
`define FN_POWER_DOWN     4'h7

// Mode status fields
`define MS_RGMII          0
`define MS_NAND_TREE      1
`define MS_POWER_DOWN     2
`define MS_RESERVED       3
`define MS_WAKE_IND       4
`define MS_WAKE_IRQ       5
`define MS_LED_INDIV      6
`define MS_FN_LSB         8

// Clock control fields
`define CC_CLK_ENABLE     0
`define CC_SRC_RECOVERED  1
`define CC_BCAST_ENABLE   2

// Advertisement fields
`define ADV_1000_FULL     0
`define ADV_1000_HALF     1
`define ADV_100_FULL      2
`define ADV_100_HALF      3
`define ADV_10_FULL       4
`define ADV_10_HALF       5

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

/* File: hw/strap_sync.v */
// Two-stage synchroniser for strap pins and the raw chip reset
`timescale 1ns/1ps
module strap_sync #(
  parameter WIDTH = 11
) (
  input  wire             aclk,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // Plain flops, no reset: pins must be sampled even during reset
  always @(posedge aclk) begin
    meta     <= async_in;
    sync_out <= meta;
  end
endmodule

/* File: hw/clock_out_gate.v */
// Reference clock output gate and source mux
`timescale 1ns/1ps
module clock_out_gate (
  input  wire aclk,
  input  wire aresetn,
  input  wire enable,
  input  wire use_recovered,
  input  wire local_clk_level,
  input  wire recovered_clk_level,
  output reg  clk_out,
  output reg  clk_out_en_n
);
  // Source levels are retimed here; the real pad would use a glitch-free mux
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_out      <= 1'b0;
      clk_out_en_n <= 1'b1;
    end else begin
      clk_out      <= enable & (use_recovered ? recovered_clk_level
                                              : local_clk_level);
      clk_out_en_n <= ~enable;
    end
  end
endmodule

/* File: hw/strap_latch_decode.v */
// Strap capture at chip reset release and decode into operating settings
//
// Behaviour
// - Sample all straps when chip reset rises and hold them.
// - Codes 8,A,C,E are RGMII; wake pin, gigabit full only, 10/100 per code.
// - Code 4 is NAND tree test, 7 is power down; others reserved.
// - Three address straps form low bits; upper two address bits zero.
// - Broadcast strap sets reset default of broadcast enable bit.
// - Broadcast enable bit loads the inverse of the strap level.
// - Reference clock strap high drives 125 MHz clock out, low does not.
// - Clock source defaults to local clock; recovered clock selectable.
// - Indicator strap 1 means individual LEDs, 0 means tri-color.
// - Broadcast strap 0 answers address zero too; 1 only own address.
// - Address strap pulled up reads 1, pulled down 0; range 0 to 7.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "strap_latch_map.vh"
module strap_latch_decode (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        chip_reset_n,
  input  wire [3:0]  function_straps,
  input  wire [2:0]  mgmt_address_straps,
  input  wire        broadcast_address_strap,
  input  wire        ref_clock_out_strap,
  input  wire        indicator_style_strap,
  input  wire        local_clk_level,
  input  wire        recovered_clk_level,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [4:0]  mgmt_address,
  output reg         broadcast_address_enable,
  output reg         rgmii_mode,
  output reg         nand_tree_mode,
  output reg         power_down_mode,
  output reg         reserved_mode,
  output reg         wake_event_on_indicator,
  output reg         wake_event_on_irq_pin,
  output reg  [5:0]  advertise,
  output reg         indicator_individual,
  output wire        ref_clock_out_pin,
  output wire        ref_clock_out_pin_en_n
);
  wire [12:0] pins_sync;
  reg         chip_reset_prev;

  // Clock levels come from other domains, so they pass the same two flops
  strap_sync #(
    .WIDTH (13)
  ) u_sync (
    .aclk     (aclk),
    .async_in ({recovered_clk_level, local_clk_level, chip_reset_n,
                indicator_style_strap, ref_clock_out_strap,
                broadcast_address_strap, mgmt_address_straps,
                function_straps}),
    .sync_out (pins_sync)
  );

  wire [3:0] fn_sync    = pins_sync[3:0];
  wire [2:0] addr_sync  = pins_sync[6:4];
  wire       bcast_sync = pins_sync[7];
  wire       clk_sync   = pins_sync[8];
  wire       led_sync   = pins_sync[9];
  wire       crst_sync  = pins_sync[10];
  wire       lclk_sync  = pins_sync[11];
  wire       rclk_sync  = pins_sync[12];
  wire       release_edge = crst_sync & ~chip_reset_prev;

  reg [5:0] next_advertise;
  reg       next_reserved;

  // Latched straps, plus the writable clock source select
  reg [3:0] fn_code;
  reg [2:0] addr_latch;
  reg       bcast_latch;
  reg       clk_latch;
  reg       led_latch;
  reg       clk_src_recovered;

  // Bus state
  reg        aw_held;
  reg        w_held;
  reg [4:0]  aw_addr;
  reg        aw_hit;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  always @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset_prev <= 1'b0;
    end else begin
      chip_reset_prev <= crst_sync;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      fn_code     <= 4'h0;
      addr_latch  <= 3'h0;
      bcast_latch <= 1'b1;
      clk_latch   <= 1'b0;
      led_latch   <= 1'b0;
    end else if (release_edge) begin
      fn_code     <= fn_sync;
      addr_latch  <= addr_sync;
      bcast_latch <= bcast_sync;
      clk_latch   <= clk_sync;
      led_latch   <= led_sync;
    end
  end

  // Decoded outputs, each from a flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      mgmt_address             <= 5'h00;
      rgmii_mode               <= 1'b0;
      nand_tree_mode           <= 1'b0;
      power_down_mode          <= 1'b0;
      reserved_mode            <= 1'b0;
      wake_event_on_indicator  <= 1'b0;
      wake_event_on_irq_pin    <= 1'b0;
      advertise                <= 6'h00;
      indicator_individual     <= 1'b0;
    end else begin
      mgmt_address            <= {2'h0, addr_latch};
      rgmii_mode              <= (fn_code == `FN_RGMII_WAKE_IND) |
                                 (fn_code == `FN_RGMII_WAKE_IRQ) |
                                 (fn_code == `FN_RGMII_GIG_ONLY) |
                                 (fn_code == `FN_RGMII_PLAIN);
      wake_event_on_indicator <= (fn_code == `FN_RGMII_WAKE_IND);
      wake_event_on_irq_pin   <= (fn_code == `FN_RGMII_WAKE_IRQ);
      advertise               <= next_advertise;
      nand_tree_mode          <= (fn_code == `FN_NAND_TREE);
      power_down_mode         <= (fn_code == `FN_POWER_DOWN);
      reserved_mode           <= next_reserved;
      indicator_individual    <= led_latch;
    end
  end

  always @* begin
    next_advertise = 6'h00;
    next_reserved  = 1'b0;
    case (fn_code)
      `FN_RGMII_WAKE_IND, `FN_RGMII_WAKE_IRQ, `FN_RGMII_PLAIN: begin
        next_advertise[`ADV_1000_FULL] = 1'b1;
        next_advertise[`ADV_100_FULL]  = 1'b1;
        next_advertise[`ADV_100_HALF]  = 1'b1;
        next_advertise[`ADV_10_FULL]   = 1'b1;
        next_advertise[`ADV_10_HALF]   = 1'b1;
      end
      `FN_RGMII_GIG_ONLY: begin
        next_advertise[`ADV_1000_FULL] = 1'b1;
      end
      `FN_NAND_TREE, `FN_POWER_DOWN: begin
        next_reserved = 1'b0;
      end
      default: begin
        next_reserved = 1'b1;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      broadcast_address_enable <= 1'b0;
      clk_src_recovered        <= 1'b0;
    end else if (release_edge) begin
      broadcast_address_enable <= ~bcast_sync;
      clk_src_recovered        <= 1'b0;
    end else if (w_held && aw_held && !s_axi_bvalid &&
                 aw_hit && aw_addr == `REG_CLOCK_CTRL && w_strb[0]) begin
      broadcast_address_enable <= w_data[`CC_BCAST_ENABLE];
      clk_src_recovered        <= w_data[`CC_SRC_RECOVERED];
    end
  end

  clock_out_gate u_clk (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .enable              (clk_latch),
    .use_recovered       (clk_src_recovered),
    .local_clk_level     (lclk_sync),
    .recovered_clk_level (rclk_sync),
    .clk_out             (ref_clock_out_pin),
    .clk_out_en_n        (ref_clock_out_pin_en_n)
  );

  // AXI write: address and data in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 5'h00;
      aw_hit        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr[4:0];
        aw_hit        <= (s_axi_awaddr[31:5] == 27'h0000000);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_hit && aw_addr == `REG_CLOCK_CTRL) ?
                        `RESP_OKAY : (aw_hit && aw_addr[1:0] == 2'h0 &&
                        aw_addr <= `REG_RAW_STRAPS) ? `RESP_OKAY
                        : `RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read data; status registers ignore writes
  reg [31:0] next_rdata;
  reg        next_rhit;

  always @* begin
    next_rdata = 32'h00000000;
    next_rhit  = (s_axi_araddr[31:5] == 27'h0000000);
    case (s_axi_araddr[4:0])
      `REG_MODE_STATUS: begin
        next_rdata[`MS_RGMII]      = rgmii_mode;
        next_rdata[`MS_NAND_TREE]  = nand_tree_mode;
        next_rdata[`MS_POWER_DOWN] = power_down_mode;
        next_rdata[`MS_RESERVED]   = reserved_mode;
        next_rdata[`MS_WAKE_IND]   = wake_event_on_indicator;
        next_rdata[`MS_WAKE_IRQ]   = wake_event_on_irq_pin;
        next_rdata[`MS_LED_INDIV]  = indicator_individual;
        next_rdata[`MS_FN_LSB+3:`MS_FN_LSB] = fn_code;
      end
      `REG_MGMT_ADDR:  next_rdata[4:0] = mgmt_address;
      `REG_CLOCK_CTRL: begin
        next_rdata[`CC_CLK_ENABLE]    = clk_latch;
        next_rdata[`CC_SRC_RECOVERED] = clk_src_recovered;
        next_rdata[`CC_BCAST_ENABLE]  = broadcast_address_enable;
      end
      `REG_ADV_STATUS: next_rdata[5:0] = advertise;
      `REG_RAW_STRAPS: next_rdata[9:0] = {led_latch, clk_latch, bcast_latch,
                                          addr_latch, fn_code};
      default: next_rhit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rhit ? next_rdata : 32'h00000000;
      s_axi_rresp   <= next_rhit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: verif/strap_latch_decode_properties.sv */
// Checker for strap capture and decoded settings
`timescale 1ns/1ps
module strap_latch_checker (
  input wire       aclk,
  input wire       aresetn,
  input wire       chip_reset_n,
  input wire [3:0] function_straps,
  input wire [2:0] mgmt_address_straps,
  input wire       broadcast_address_strap,
  input wire       ref_clock_out_strap,
  input wire       indicator_style_strap,
  input wire [4:0] mgmt_address,
  input wire       broadcast_address_enable,
  input wire       rgmii_mode,
  input wire [5:0] advertise,
  input wire       indicator_individual,
  input wire       ref_clock_out_pin,
  input wire       ref_clock_out_pin_en_n
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Board holds straps past this point
  sequence latched;
    $rose(chip_reset_n) ##6 1'b1;
  endsequence
  addr_upper_a: assert property (mgmt_address[4:3] == 2'h0)
    else $error("address upper bits set");
  addr_low_a: assert property (
    latched |-> mgmt_address[2:0] == mgmt_address_straps)
    else $error("address low bits wrong");
  bcast_inverse_a: assert property (
    latched |-> broadcast_address_enable == !broadcast_address_strap)
    else $error("broadcast enable not inverted");
  rgmii_decode_a: assert property (
    latched |-> rgmii_mode == (function_straps[3] && !function_straps[0]))
    else $error("rgmii decode wrong");
  gig_half_a: assert property (advertise[1] == 1'h0)
    else $error("gigabit half advertised");
  clk_enable_a: assert property (
    latched |-> ref_clock_out_pin_en_n == !ref_clock_out_strap)
    else $error("clock enable wrong");
  clk_quiet_a: assert property (
    ref_clock_out_pin_en_n [*3] |-> !ref_clock_out_pin)
    else $error("clock driven while off");
  led_style_a: assert property (
    latched |-> indicator_individual == indicator_style_strap)
    else $error("indicator style wrong");
  hold_value_a: assert property (
    chip_reset_n [*8] |-> $stable(mgmt_address))
    else $error("latched address moved");
endmodule
bind strap_latch_decode strap_latch_checker u_chk (
  .aclk, .aresetn, .chip_reset_n, .function_straps, .mgmt_address_straps,
  .broadcast_address_strap, .ref_clock_out_strap, .indicator_style_strap,
  .mgmt_address, .broadcast_address_enable, .rgmii_mode, .advertise,
  .indicator_individual, .ref_clock_out_pin, .ref_clock_out_pin_en_n);

/* File: verif/strap_board.sv */
// Board model: strap resistors, chip reset source, clock levels
`timescale 1ns/1ps
module strap_board (
  input  wire       aclk,
  output reg        chip_reset_n,
  output reg  [9:0] straps,
  output reg        local_clk_level,
  output reg        recovered_clk_level
);
  initial begin
    chip_reset_n = 1'h0;
    straps = 10'h000;
    local_clk_level = 1'h0;
    recovered_clk_level = 1'h0;
  end
  // Recovered clock slower, so the two sources differ
  always @(posedge aclk) begin
    local_clk_level <= !local_clk_level;
    if (local_clk_level)
      recovered_clk_level <= !recovered_clk_level;
  end
  task strap_cycle(input [9:0] cfg);
    begin
      @(posedge aclk);
      chip_reset_n <= 1'h0;
      @(posedge aclk);
      straps <= cfg;
      repeat (6) @(posedge aclk);
      chip_reset_n <= 1'h1;
      repeat (8) @(posedge aclk);
    end
  endtask
  task strap_wiggle(input [9:0] cfg);
    begin
      straps <= cfg;
      repeat (8) @(posedge aclk);
    end
  endtask
endmodule

/* File: verif/strap_latch_decode_tb.sv */
// Bench for strap capture, decode and register view
`timescale 1ns/1ps
`include "strap_latch_map.vh"
module strap_latch_decode_tb;
  reg         aclk = 1'h0, aresetn = 1'h0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  reg  [31:0] s_axi_araddr = 32'h0, rd;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_bready = 1'h1;
  reg         s_axi_rready = 1'h1, rg;
  reg  [1:0]  rr;
  wire        chip_reset_n, local_clk_level, recovered_clk_level;
  wire [9:0]  straps;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0]  mgmt_address;
  wire [5:0]  advertise;
  wire        broadcast_address_enable, rgmii_mode, nand_tree_mode;
  wire        power_down_mode, reserved_mode, wake_event_on_indicator;
  wire        wake_event_on_irq_pin, indicator_individual;
  wire        ref_clock_out_pin, ref_clock_out_pin_en_n;
  integer     n_fail = 0, checks_done = 0, cyc = 0, c;
  always #2.5 aclk = !aclk;
  strap_board u_board (.aclk, .chip_reset_n, .straps, .local_clk_level,
    .recovered_clk_level);
  strap_latch_decode u_dut (.aclk, .aresetn, .chip_reset_n,
    .function_straps(straps[3:0]), .mgmt_address_straps(straps[6:4]),
    .broadcast_address_strap(straps[7]), .ref_clock_out_strap(straps[8]),
    .indicator_style_strap(straps[9]), .local_clk_level,
    .recovered_clk_level, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mgmt_address, .broadcast_address_enable, .rgmii_mode,
    .nand_tree_mode, .power_down_mode, .reserved_mode,
    .wake_event_on_indicator, .wake_event_on_irq_pin, .advertise,
    .indicator_individual, .ref_clock_out_pin, .ref_clock_out_pin_en_n);
  task chk(input [31:0] got, input [31:0] exp, input [8*6:1] what);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("FAIL %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Ready lines stay high, so no release races a new request
  task axi_wr(input [31:0] a, input [31:0] d);
    reg aw, w, done;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      aw = 1'h1;
      w = 1'h1;
      done = 1'h0;
      while (!done) begin
        @(posedge aclk);
        if (aw && s_axi_awready) begin
          aw = 1'h0;
          s_axi_awvalid <= 1'h0;
        end
        if (w && s_axi_wready) begin
          w = 1'h0;
          s_axi_wvalid <= 1'h0;
        end
        done = s_axi_bvalid;
      end
    end
  endtask
  task axi_rd(input [31:0] a, output [31:0] d, output [1:0] r);
    reg ar, done;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      ar = 1'h1;
      done = 1'h0;
      while (!done) begin
        @(posedge aclk);
        if (ar && s_axi_arready) begin
          ar = 1'h0;
          s_axi_arvalid <= 1'h0;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = s_axi_rvalid;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (c = 0; c < 16; c = c + 1) begin
      u_board.strap_cycle({c[2:0], c[2:0], c[3:0]});
      rg = c[3] && !c[0];
      chk({rgmii_mode, nand_tree_mode, power_down_mode, reserved_mode,
        wake_event_on_indicator, wake_event_on_irq_pin}, {rg, c == 4,
        c == 7, !(rg || c == 4 || c == 7), c == 8, c == 10}, "mode");
      if (rg)
        chk(advertise, c == 12 ? 6'h01 : 6'h3D, "adv");
      chk(mgmt_address, {2'h0, c[2:0]}, "addr");
      chk(broadcast_address_enable, !c[0], "bcast");
      chk(ref_clock_out_pin_en_n, !c[1], "clk_en");
      // Alternating level makes the pipeline delay odd
      chk(ref_clock_out_pin, c[1] & !local_clk_level, "clk");
      chk(indicator_individual, c[2], "led");
      axi_rd(`REG_RAW_STRAPS, rd, rr);
      chk(rd, {c[2:0], c[2:0], c[3:0]}, "raw");
    end
    $display("test decode done");
    axi_rd(`REG_CLOCK_CTRL, rd, rr);
    chk(rd, 32'h1, "ctrl");
    axi_wr(`REG_CLOCK_CTRL, 32'h6);
    chk(s_axi_bresp, `RESP_OKAY, "bresp");
    axi_rd(`REG_CLOCK_CTRL, rd, rr);
    chk(rd, 32'h7, "ctrl");
    chk(broadcast_address_enable, 1'h1, "bcast");
    axi_wr(`REG_MGMT_ADDR, 32'h1F);
    chk(s_axi_bresp, `RESP_OKAY, "bresp");
    axi_rd(`REG_MGMT_ADDR, rd, rr);
    chk(rd, 32'h7, "addr");
    axi_rd(32'h14, rd, rr);
    chk(rr, `RESP_DECERR, "rresp");
    chk(rd, 32'h0, "unmap");
    u_board.strap_cycle(10'h05E);
    axi_rd(`REG_CLOCK_CTRL, rd, rr);
    chk(rd, 32'h4, "ctrl");
    $display("test control done");
    u_board.strap_wiggle(10'h3A1);
    chk(mgmt_address, 5'h05, "addr");
    chk({rgmii_mode, indicator_individual}, 2'h2, "hold");
    $display("test hold done");
    final_report;
  end
endmodule
